/* rtl/ahiop_pkg.sv */
// Shared constants for the address-high and quasi I/O port block
package ahiop_pkg;
  // Clock rate and derived timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned STRONG_HI_NS   = 20;   // Strong pull-up burst
  localparam int unsigned STRONG_HI_CYC  =
    ((STRONG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((STRONG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Timer prescale counts in oscillator clocks
  localparam int unsigned TMR_DIV_SLOW   = 12;
  localparam int unsigned TMR_DIV_FAST   = 4;
  localparam int unsigned TMR_CNT_W      = 4;
  // Reset values
  localparam logic [7:0]  AH_LATCH_RST   = 8'hff;
  localparam logic [7:0]  IO_LATCH_RST   = 8'hff;
  localparam logic [7:0]  AH_PINS_RST    = 8'hff;
  localparam logic [7:0]  SYNC_RST       = 8'hff;
  localparam logic [7:0]  LO_BYTE_RST    = 8'h00;
  localparam logic [7:0]  LO_OE_RST      = 8'h00;
  localparam logic [7:0]  DRV_OE_RST     = 8'h00;
  localparam logic [4:0]  ALT_IN_RST     = 5'h1f;
  // Quasi I/O bit positions of alternate functions
  localparam int unsigned BIT_SER_RX     = 0;
  localparam int unsigned BIT_SER_TX     = 1;
  localparam int unsigned BIT_INT_ZERO   = 2;
  localparam int unsigned BIT_INT_ONE    = 3;
  localparam int unsigned BIT_TMR_ZERO   = 4;
  localparam int unsigned BIT_TMR_ONE    = 5;
  localparam int unsigned BIT_WR_STB     = 6;
  localparam int unsigned BIT_RD_STB     = 7;
  // Address byte split
  localparam int unsigned ADDR_HI_MSB    = 15;
  localparam int unsigned ADDR_HI_LSB    = 8;
endpackage

/* rtl/ahiop_qp_if.sv */
// Internal carrier between port control and quasi pin drivers
`timescale 1ns/1ps
interface ahiop_qp_if;
  logic [7:0] level;    // Wanted pin level per bit
  logic [7:0] pin_out;  // Registered pin output value
  logic [7:0] pin_oe;   // Registered strong drive enable
  logic [7:0] pin_pu;   // Registered weak pull-up enable
  modport ctrl (output level, input pin_out, input pin_oe, input pin_pu);
  modport drv  (input level, output pin_out, output pin_oe, output pin_pu);
endinterface

/* rtl/ahiop_qport.sv */
// Quasi-bidirectional pin drivers with strong high burst
`timescale 1ns/1ps
module ahiop_qport
  import ahiop_pkg::*;
#(
  parameter int unsigned BURST_CYC = STRONG_HI_CYC
) (
  input  wire logic clk,  // Processor clock
  input  wire logic rst,  // Asynchronous reset, active high
  ahiop_qp_if.drv   qp    // Level in, pin drive out
);
  localparam int unsigned BW = $clog2(BURST_CYC + 1);
  localparam logic [BW-1:0] BURST_LD = BW'(BURST_CYC);

  logic [7:0] prev_r, prev_nxt;
  logic [7:0] out_r, out_nxt;
  logic [7:0] oe_r, oe_nxt;
  logic [7:0] pu_r, pu_nxt;

  assign qp.pin_out = out_r;
  assign qp.pin_oe  = oe_r;
  assign qp.pin_pu  = pu_r;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      logic [BW-1:0] burst_r, burst_nxt;
      // Per-bit driver: low drives hard, rising edge bursts high
      always_comb begin
        burst_nxt   = burst_r;
        prev_nxt[g] = qp.level[g];
        if (!qp.level[g]) begin
          burst_nxt = '0;
        end else if (!prev_r[g]) begin
          burst_nxt = BURST_LD;
        end else if (burst_r != '0) begin
          burst_nxt = burst_r - 1'b1;
        end
        out_nxt[g] = qp.level[g];
        oe_nxt[g]  = !qp.level[g] || (burst_nxt != '0);
        pu_nxt[g]  = qp.level[g];
      end
      // Burst counter register
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          burst_r <= '0;
        end else begin
          burst_r <= burst_nxt;
        end
      end
    end
  endgenerate

  // Pin drive registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= IO_LATCH_RST;
      out_r  <= IO_LATCH_RST;
      oe_r   <= DRV_OE_RST;
      pu_r   <= IO_LATCH_RST;
    end else begin
      prev_r <= prev_nxt;
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
      pu_r   <= pu_nxt;
    end
  end
endmodule

/* rtl/ahiop_top.sv */
// Address-high port and quasi-bidirectional I/O port pin logic
`timescale 1ns/1ps
module ahiop_top
  import ahiop_pkg::*;
(
  input  wire logic       clk,                  // Processor clock
  input  wire logic       rst,                  // Async reset, active high
  input  wire logic       mem_access,           // External access active
  input  wire logic       ri_move,              // Indirect 8-bit data move
  input  wire logic [15:0] mem_addr,            // Access address
  input  wire logic       ah_latch_we,          // Write address-high latch
  input  wire logic [7:0] ah_latch_wdata,       // Latch write data
  output logic      [7:0] ah_latch_rdata,       // Latch read data
  output logic      [7:0] addr_high_port_bits,  // Address-high pins
  input  wire logic       addr_strobe,          // Address latch strobe
  output logic      [7:0] addr_low_out,         // Low byte on shared bus
  output logic      [7:0] addr_low_oe,          // Low byte drive enable
  input  wire logic       io_latch_we,          // Write I/O port latch
  input  wire logic [7:0] io_latch_wdata,       // I/O latch write data
  output logic      [7:0] io_latch_rdata,       // I/O latch contents
  output logic      [7:0] io_pin_rdata,         // Synced I/O pin levels
  input  wire logic [7:0] quasi_io_port_bits_in,  // I/O pin levels
  output logic      [7:0] quasi_io_port_bits_out, // I/O pin value
  output logic      [7:0] quasi_io_port_bits_oe,  // Strong drive enable
  output logic      [7:0] quasi_io_port_bits_pu,  // Weak pull-up enable
  input  wire logic       serial_zero_transmit, // Serial transmit level
  input  wire logic       wr_strobe_n,          // Write strobe, low active
  input  wire logic       rd_strobe_n,          // Read strobe, low active
  output logic            serial_zero_receive,  // Serial receive level
  output logic            ext_interrupt_zero,   // Interrupt zero level
  output logic            ext_interrupt_one,    // Interrupt one level
  output logic            timer_zero_count_in,  // Timer zero count level
  output logic            timer_one_count_in,   // Timer one count level
  input  wire logic       timer_fast,           // Select fast prescale
  output logic            timer_tick            // Timer increment enable
);
  // Address-high latch and the address pins it may feed
  logic [7:0]           ah_latch_r;
  logic [7:0]           ah_latch_nxt;
  logic [7:0]           ah_pins_r;
  logic [7:0]           ah_pins_nxt;

  // Low address byte on the shared bus
  logic [7:0]           lo_out_r;
  logic [7:0]           lo_out_nxt;
  logic [7:0]           lo_oe_r;
  logic [7:0]           lo_oe_nxt;

  // I/O port latch and the level each pin should show
  logic [7:0]           io_latch_r;
  logic [7:0]           io_latch_nxt;
  logic [7:0]           alt_out;
  logic [7:0]           level;

  // Pin synchroniser
  logic [7:0]           sync1_r;
  logic [7:0]           sync2_r;

  // Pin reads and alternate inputs
  logic [7:0]           pin_rd_r;
  logic [7:0]           pin_rd_nxt;
  logic [4:0]           alt_in_r;
  logic [4:0]           alt_in_nxt;

  // Timer prescaler
  logic [TMR_CNT_W-1:0] tdiv_r;
  logic [TMR_CNT_W-1:0] tdiv_nxt;
  logic [TMR_CNT_W-1:0] tdiv_last;
  logic                 tick_r;
  logic                 tick_nxt;

  // Alternate output levels; bits with no output stay at one
  // so that their weak pull-up keeps them usable as inputs
  function automatic logic [7:0] alt_levels(
    input logic tx,
    input logic wr_n,
    input logic rd_n
  );
    logic [7:0] v;
    v             = 8'hff;
    v[BIT_SER_TX] = tx;
    v[BIT_WR_STB] = wr_n;
    v[BIT_RD_STB] = rd_n;
    return v;
  endfunction

  // Upper address byte of one access; indirect moves use the latch
  function automatic logic [7:0] addr_high_src(
    input logic        indirect,
    input logic [15:0] addr,
    input logic [7:0]  latch
  );
    logic [7:0] v;
    if (indirect) begin
      v = latch;
    end else begin
      v = addr[ADDR_HI_MSB:ADDR_HI_LSB];
    end
    return v;
  endfunction

  // Pin levels that feed the alternate inputs, receive first
  function automatic logic [4:0] alt_inputs(
    input logic [7:0] lv
  );
    logic [4:0] v;
    v[0] = lv[BIT_SER_RX];
    v[1] = lv[BIT_INT_ZERO];
    v[2] = lv[BIT_INT_ONE];
    v[3] = lv[BIT_TMR_ZERO];
    v[4] = lv[BIT_TMR_ONE];
    return v;
  endfunction

  // Last prescaler count for the selected timer rate
  function automatic logic [TMR_CNT_W-1:0] tick_last(
    input logic fast
  );
    logic [TMR_CNT_W-1:0] v;
    if (fast) begin
      v = TMR_CNT_W'(TMR_DIV_FAST - 1);
    end else begin
      v = TMR_CNT_W'(TMR_DIV_SLOW - 1);
    end
    return v;
  endfunction

  // Pin drivers; the carrier holds the wanted level and the drive
  ahiop_qp_if qp ();

  ahiop_qport u_qport (
    .clk (clk),
    .rst (rst),
    .qp  (qp.drv)
  );

  // Alternate outputs; input-only bits sit at one for the pull-up
  always_comb begin
    alt_out = alt_levels(serial_zero_transmit, wr_strobe_n, rd_strobe_n);
  end

  // A latch bit at zero holds its pin low whatever the alternate
  // output does; a one lets the alternate through
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_level
      assign level[b] = io_latch_r[b] & alt_out[b];
    end
  endgenerate
  assign qp.level = level;

  // Address-high latch written by software; it reaches the pins
  // only through an indirect data move
  always_comb begin
    ah_latch_nxt = ah_latch_r;
    if (ah_latch_we) begin
      ah_latch_nxt = ah_latch_wdata;
    end
  end

  // Address pins follow each access and hold while idle, so the
  // latch never stands in for the address of a normal access
  always_comb begin
    ah_pins_nxt = ah_pins_r;
    if (mem_access) begin
      ah_pins_nxt = addr_high_src(ri_move, mem_addr, ah_latch_r);
    end
  end

  // Low byte captured while the address strobe is high; the bus
  // turns into the data path once the strobe falls, so it is held
  always_comb begin
    lo_oe_nxt  = {8{addr_strobe}};
    lo_out_nxt = lo_out_r;
    if (addr_strobe) begin
      lo_out_nxt = mem_addr[ADDR_HI_LSB-1:0];
    end
  end

  // I/O port latch written by software; a zero turns on the strong
  // pull-down, a one after a zero starts the high burst
  always_comb begin
    io_latch_nxt = io_latch_r;
    if (io_latch_we) begin
      io_latch_nxt = io_latch_wdata;
    end
  end

  // Pin reads and alternate inputs come after the synchroniser
  always_comb begin
    pin_rd_nxt = sync2_r;
    alt_in_nxt = alt_inputs(sync2_r);
  end

  // Prescaler: one-cycle tick every 12 or 4 clocks; a count past
  // the fast limit wraps at once when the rate changes
  always_comb begin
    tdiv_last = tick_last(timer_fast);
    tdiv_nxt  = tdiv_r + 1'b1;
    tick_nxt  = 1'b0;
    if (tdiv_r >= tdiv_last) begin
      tdiv_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  // Address-high latch and pin registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ah_latch_r <= AH_LATCH_RST;
      ah_pins_r  <= AH_PINS_RST;
    end else begin
      ah_latch_r <= ah_latch_nxt;
      ah_pins_r  <= ah_pins_nxt;
    end
  end

  // Low byte registers; the bus is released in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_out_r <= LO_BYTE_RST;
      lo_oe_r  <= LO_OE_RST;
    end else begin
      lo_out_r <= lo_out_nxt;
      lo_oe_r  <= lo_oe_nxt;
    end
  end

  // I/O port latch register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_latch_r <= IO_LATCH_RST;
    end else begin
      io_latch_r <= io_latch_nxt;
    end
  end

  // Two flops settle a pin that changes off the clock; nothing
  // but the second flop reads the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= quasi_io_port_bits_in;
      sync2_r <= sync1_r;
    end
  end

  // Pin read and alternate input registers, three clocks behind
  // the pin itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_rd_r <= SYNC_RST;
      alt_in_r <= ALT_IN_RST;
    end else begin
      pin_rd_r <= pin_rd_nxt;
      alt_in_r <= alt_in_nxt;
    end
  end

  // Timer prescaler registers; the count restarts from zero in
  // reset so the first tick lands a full period later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdiv_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tdiv_r <= tdiv_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Outputs straight from registers
  assign ah_latch_rdata         = ah_latch_r;
  assign addr_high_port_bits    = ah_pins_r;
  assign addr_low_out           = lo_out_r;
  assign addr_low_oe            = lo_oe_r;
  assign io_latch_rdata         = io_latch_r;
  assign io_pin_rdata           = pin_rd_r;
  assign quasi_io_port_bits_out = qp.pin_out;
  assign quasi_io_port_bits_oe  = qp.pin_oe;
  assign quasi_io_port_bits_pu  = qp.pin_pu;
  assign serial_zero_receive    = alt_in_r[0];
  assign ext_interrupt_zero     = alt_in_r[1];
  assign ext_interrupt_one      = alt_in_r[2];
  assign timer_zero_count_in    = alt_in_r[3];
  assign timer_one_count_in     = alt_in_r[4];
  assign timer_tick             = tick_r;
endmodule

/* sim/ahiop_pins.sv */
// Far-side pin model: board pull-downs against the port drivers
`timescale 1ns/1ps
module ahiop_pins (
  input  wire logic [7:0] drv_out, // Driven level
  input  wire logic [7:0] drv_oe,  // Strong drive on
  input  wire logic [7:0] drv_pu,  // Weak pull-up on
  input  wire logic [7:0] ext_low, // Board pulls low
  output logic      [7:0] pin      // Resolved level
);
  // Board low beats a weak pull-up; a bare pin flips its last value
  always @(drv_out or drv_oe or drv_pu or ext_low) begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = ext_low[i] ? 1'h0 : drv_oe[i] ? drv_out[i] :
        drv_pu[i] ? 1'h1 : ~pin[i];
    end
  end
endmodule

/* sim/ahiop_assertions.sv */
// Port relations checked at the top module of the port block
`timescale 1ns/1ps
module ahiop_assertions
  import ahiop_pkg::*;
(
  input wire logic        clk,                    // Clock
  input wire logic        rst,                    // Reset
  input wire logic        mem_access,             // Access
  input wire logic        ri_move,                // Indirect
  input wire logic [15:0] mem_addr,               // Address
  input wire logic [7:0]  ah_latch_rdata,         // Latch
  input wire logic [7:0]  addr_high_port_bits,    // Pins
  input wire logic        io_latch_we,            // Write
  input wire logic [7:0]  io_latch_wdata,         // Data
  input wire logic [7:0]  io_latch_rdata,         // Latch
  input wire logic [7:0]  quasi_io_port_bits_out, // Out
  input wire logic [7:0]  quasi_io_port_bits_oe,  // Drive
  input wire logic [7:0]  quasi_io_port_bits_pu,  // Pull-up
  input wire logic        wr_strobe_n,            // Strobe
  input wire logic        timer_fast,             // Rate
  input wire logic        timer_tick              // Tick
);
  default clocking @(posedge clk);
  endclocking
  default disable iff rst;
  // Zero-to-one write followed by two quiet cycles
  sequence rise_s;
    io_latch_we && io_latch_wdata[0] && !io_latch_rdata[0]
      ##1 !io_latch_we [*2];
  endsequence
  // Two strong-high cycles, then weak pull-up only
  sequence burst_s;
    (quasi_io_port_bits_oe[0] && quasi_io_port_bits_out[0]) [*2]
      ##1 (!quasi_io_port_bits_oe[0] && quasi_io_port_bits_pu[0]);
  endsequence
  AST_ADDR: assert property (mem_access && !ri_move |=>
    {addr_high_port_bits, 8'h00} == ($past(mem_addr) & 16'hff00))
    else $error("address high byte wrong");
  AST_RI: assert property (mem_access && ri_move |=>
    addr_high_port_bits == $past(ah_latch_rdata)) else $error("ri byte");
  AST_HOLD: assert property (!mem_access |=>
    $stable(addr_high_port_bits)) else $error("pins moved while idle");
  AST_LOW: assert property (io_latch_we && !io_latch_wdata[0] |=> ##1
    quasi_io_port_bits_oe[0] && !quasi_io_port_bits_out[0]
    && !quasi_io_port_bits_pu[0]) else $error("no strong low");
  AST_BURST: assert property (rise_s |-> burst_s)
    else $error("strong high burst wrong");
  AST_ALT: assert property (!io_latch_rdata[1] |=>
    quasi_io_port_bits_oe[1] && !quasi_io_port_bits_out[1])
    else $error("alternate passed a zero latch");
  AST_WR: assert property (io_latch_rdata[6] && !wr_strobe_n |=>
    quasi_io_port_bits_oe[6] && !quasi_io_port_bits_out[6])
    else $error("write strobe not on pin");
  AST_TICK: assert property (timer_tick && timer_fast
    ##1 timer_fast [*3] |=> timer_tick) else $error("fast tick late");
endmodule
bind ahiop_top ahiop_assertions u_chk (.clk(clk), .rst(rst),
  .mem_access(mem_access), .ri_move(ri_move), .mem_addr(mem_addr),
  .ah_latch_rdata(ah_latch_rdata), .addr_high_port_bits(addr_high_port_bits),
  .io_latch_we(io_latch_we), .io_latch_wdata(io_latch_wdata),
  .io_latch_rdata(io_latch_rdata), .wr_strobe_n(wr_strobe_n),
  .quasi_io_port_bits_out(quasi_io_port_bits_out),
  .quasi_io_port_bits_oe(quasi_io_port_bits_oe),
  .quasi_io_port_bits_pu(quasi_io_port_bits_pu),
  .timer_fast(timer_fast), .timer_tick(timer_tick));

/* sim/ahiop_top_tb.sv */
// Self-checking bench for the address-high and quasi I/O port block
`timescale 1ns/1ps
module ahiop_top_tb;
  logic        clk, rst, mem_access, ri_move, ah_latch_we, addr_strobe;
  logic        io_latch_we, tx, wr_n, rd_n, timer_fast, tick;
  logic        rx, i0, i1, t0, t1, m_tick;
  logic [15:0] mem_addr;
  logic [7:0]  ah_wd, ah_rd, ah_pins, lo_out, lo_oe, io_wd, io_rd, io_pin;
  logic [7:0]  pin, q_out, q_oe, q_pu, ext_low;
  logic [7:0]  m_ahl, m_pins, m_lo, m_loe, m_iol, m_q;
  logic [7:0]  pq[$];
  logic [31:0] r, s;
  int          err_count = 0, n_checks = 0, seed = 57442, cyc = 0, mcnt = 0;
  ahiop_top uut (.clk(clk), .rst(rst), .mem_access(mem_access),
    .ri_move(ri_move), .mem_addr(mem_addr), .ah_latch_we(ah_latch_we),
    .ah_latch_wdata(ah_wd), .ah_latch_rdata(ah_rd),
    .addr_high_port_bits(ah_pins), .addr_strobe(addr_strobe),
    .addr_low_out(lo_out), .addr_low_oe(lo_oe), .io_latch_we(io_latch_we),
    .io_latch_wdata(io_wd), .io_latch_rdata(io_rd), .io_pin_rdata(io_pin),
    .quasi_io_port_bits_in(pin), .quasi_io_port_bits_out(q_out),
    .quasi_io_port_bits_oe(q_oe), .quasi_io_port_bits_pu(q_pu),
    .serial_zero_transmit(tx), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
    .serial_zero_receive(rx), .ext_interrupt_zero(i0),
    .ext_interrupt_one(i1), .timer_zero_count_in(t0),
    .timer_one_count_in(t1), .timer_fast(timer_fast), .timer_tick(tick));
  ahiop_pins ext (.drv_out(q_out), .drv_oe(q_oe), .drv_pu(q_pu),
    .ext_low(ext_low), .pin(pin));
  // Clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Reference model advances on each edge from the inputs it saw
  always @(posedge clk) begin
    if (!rst) begin
      m_q = m_iol & {rd_n, wr_n, 4'hf, tx, 1'h1};
      if (mem_access)
        m_pins = ri_move ? m_ahl : mem_addr[15:8];
      if (ah_latch_we)
        m_ahl = ah_wd;
      if (addr_strobe)
        m_lo = mem_addr[7:0];
      m_loe = addr_strobe ? 8'hff : 8'h00;
      if (io_latch_we)
        m_iol = io_wd;
      mcnt++;
      m_tick = mcnt >= (timer_fast ? 4 : 12);
      if (m_tick)
        mcnt = 0;
      pq.push_back(pin);
      void'(pq.pop_front());
    end
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 2000) begin
      err_count++;
      end_of_test();
    end
  end
  // Compare every result, drive enable on low bits only, then drive fresh random inputs
  task automatic step();
    chk(ah_pins, m_pins);
    chk(ah_rd, m_ahl);
    chk(lo_out, m_lo);
    chk(lo_oe, m_loe);
    chk(io_rd, m_iol);
    chk(q_out, m_q);
    chk(q_pu, m_q);
    chk(q_oe & ~m_q, ~m_q);
    chk(io_pin, pq[0]);
    chk({2'h0, t1, t0, i1, i0, 1'h0, rx}, pq[0] & 8'h3d);
    chk({7'h0, tick}, {7'h0, m_tick});
    r = $random(seed);
    s = $random(seed);
    {mem_access, ri_move, ah_latch_we, addr_strobe, tx} = r[4:0];
    io_latch_we = &r[6:5];
    wr_n = r[7] | r[8];
    rd_n = r[9] | r[8];
    io_wd = r[17:10] | r[25:18];
    ext_low = s[31:24] & r[31:24] & s[23:16];
    mem_addr = s[15:0];
    ah_wd = s[23:16];
  endtask
  // Reset, check defaults, then random traffic at both timer rates
  initial begin
    {rst, wr_n, rd_n} = 3'h7;
    {mem_access, ri_move, ah_latch_we, addr_strobe, tx} = 5'h0;
    {io_latch_we, timer_fast, mem_addr, ah_wd, io_wd, ext_low} = '0;
    {m_ahl, m_pins, m_iol, m_q, m_lo, m_loe, m_tick} = {32'hffffffff, 17'h0};
    pq = '{8'hff, 8'hff, 8'hff};
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(io_rd, 8'hff);
    chk(q_pu, 8'hff);
    chk(q_oe, 8'h00);
    rst = 1'h0;
    for (int k = 0; k < 1200; k++) begin
      @(negedge clk);
      step();
      if (k == 600)
        timer_fast = 1'h1;
    end
    end_of_test();
  end
endmodule
